// >>> pmr_pkg.sv
// package: constants, states and carrier types of the power mode and reset controller
`default_nettype none
package pmr_pkg;

  // clock rate and reset pin timing
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned RST_GLITCH_NS     = 20;
  localparam int unsigned RST_MIN_PULSE_NS  = 50;
  localparam int unsigned RST_GLITCH_CYC_RAW = (RST_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_PULSE_CYC_RAW  = RST_MIN_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_GLITCH_CYC    = (RST_GLITCH_CYC_RAW < 1) ? 1 : RST_GLITCH_CYC_RAW;
  localparam int unsigned RST_PULSE_CYC     = (RST_PULSE_CYC_RAW < 1) ? 1 : RST_PULSE_CYC_RAW;
  // a low level is accepted once it outlasts the glitch window, and never later than the shortest valid pulse
  localparam int unsigned RST_ACCEPT_CYC    = (RST_GLITCH_CYC < RST_PULSE_CYC) ? RST_GLITCH_CYC : RST_PULSE_CYC;
  localparam int unsigned RST_CNT_W         = 4;

  // widths
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned START_PINS  = 6;
  localparam int unsigned BOD_LEVELS  = 4;
  localparam int unsigned BOD_SEL_W   = 2;
  localparam int unsigned RST_SRCS    = 5;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PWR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_START_EN    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_START_RISE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_START_FLAG  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_BOD_CTRL    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RST_SRC     = 8'h18;

  // field positions
  localparam int unsigned PWR_DEEP_SEL_BIT   = 0;
  localparam int unsigned PWR_WDOSC_KEEP_BIT = 1;
  localparam int unsigned PWR_BOD_KEEP_BIT   = 2;
  localparam int unsigned BOD_INT_LSB        = 0;
  localparam int unsigned BOD_RST_LSB        = 2;
  localparam int unsigned BOD_RST_EN_BIT     = 4;
  localparam int unsigned ST_BOD_BIT         = 0;
  localparam int unsigned ST_PROT_LSB        = 1;
  localparam int unsigned ST_SWD_LOCK_BIT    = 3;
  localparam int unsigned ST_PWR_LSB         = 4;
  localparam int unsigned SRC_PIN_BIT        = 0;
  localparam int unsigned SRC_WDT_BIT        = 1;
  localparam int unsigned SRC_POR_BIT        = 2;
  localparam int unsigned SRC_BOD_BIT        = 3;
  localparam int unsigned SRC_SW_BIT         = 4;

  // reset values
  localparam logic [DATA_W-1:0] BOOT_ADDRESS  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RDATA_IDLE    = 32'h0000_0000;

  // reset sequence, gray along hold -> flash init -> run
  typedef enum logic [1:0] {
    SEQ_HOLD  = 2'h0,
    SEQ_FLASH = 2'h1,
    SEQ_RUN   = 2'h3
  } pmr_seq_type;

  // power mode, gray along run -> sleep -> deep sleep
  typedef enum logic [1:0] {
    PWR_RUN   = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_DEEP  = 2'h3
  } pmr_pwr_type;

  typedef enum logic [1:0] {
    PROT_NONE  = 2'h0,
    PROT_ONE   = 2'h1,
    PROT_TWO   = 2'h2,
    PROT_THREE = 2'h3
  } pmr_prot_type;

  typedef struct packed {
    logic cpu_halt;
    logic core_clk_en;
    logic internal_rc_oscillator_en;
    logic analog_pd;
    logic wdosc_pd;
    logic brownout_detector_pd;
  } pmr_power_type;

  typedef struct packed {
    logic debug_en;
    logic swd_pins_en;
    logic sector0_lock;
    logic erase_only;
    logic in_application_programming_en;
  } pmr_guard_type;

endpackage
`default_nettype wire

// >>> pmr_ctrl.sv
// module: power modes, start logic, reset combining, brownout and code read protection
//
// The strobed register port and the register addresses were decided locally.
`default_nettype none
module pmr_ctrl #(
  parameter logic [31:0] PROT_ONE_WORD   = 32'h1111_1111,  // arbitrary pattern
  parameter logic [31:0] PROT_TWO_WORD   = 32'h2222_2222,  // arbitrary pattern
  parameter logic [31:0] PROT_THREE_WORD = 32'h3333_3333,  // arbitrary pattern
  parameter bit          SHARED_SPI_SWD  = 1'b1
) (
  input  wire logic                                clock,
  input  wire logic                                reset,
  input  wire logic [pmr_pkg::ADDR_W-1:0]          reg_addr,
  input  wire logic [pmr_pkg::DATA_W-1:0]          reg_wdata,
  input  wire logic                                reg_write,
  input  wire logic                                reg_read,
  output var  logic [pmr_pkg::DATA_W-1:0]          reg_rdata_ff,
  input  wire logic                                ext_reset_n,
  input  wire logic                                watchdog_timer_reset,
  input  wire logic                                power_on_reset,
  input  wire logic                                supply_usable,
  input  wire logic [pmr_pkg::BOD_LEVELS-1:0]      supply_below_int,
  input  wire logic [pmr_pkg::BOD_LEVELS-1:0]      supply_below_rst,
  input  wire logic                                sw_reset_req,
  input  wire logic                                flash_init_done,
  input  wire logic [pmr_pkg::DATA_W-1:0]          flash_protect_word,
  input  wire logic                                irc_ready,
  input  wire logic                                cpu_sleep_req,
  input  wire logic                                periph_irq_any,
  input  wire logic [pmr_pkg::START_PINS-1:0]      start_pins,
  input  wire logic                                spi_enabled,
  output var  logic                                chip_reset_ff,
  output var  logic                                flash_init_start_ff,
  output var  logic [pmr_pkg::DATA_W-1:0]          boot_address_ff,
  output var  pmr_pkg::pmr_power_type              power_ff,
  output var  pmr_pkg::pmr_guard_type              guard_ff,
  output var  logic [pmr_pkg::START_PINS-1:0]      start_irq_ff,
  output var  logic                                brownout_irq_ff
);
  import pmr_pkg::*;

  localparam logic [RST_CNT_W-1:0] RST_ACCEPT_CNT = RST_CNT_W'(RST_ACCEPT_CYC);
  localparam logic [RST_CNT_W-1:0] RST_CNT_MAX    = '1;

  logic [RST_CNT_W-1:0]  rst_low_cnt_ff;
  logic [RST_CNT_W-1:0]  nxt_rst_low_cnt;
  logic                  pin_rst_ff;
  pmr_seq_type           seq_ff;
  pmr_seq_type           nxt_seq;
  pmr_pwr_type           pwr_ff;
  pmr_pwr_type           nxt_pwr;
  pmr_prot_type          prot_ff;
  logic [2:0]            pwr_ctrl_ff;
  logic [START_PINS-1:0] start_en_ff;
  logic [START_PINS-1:0] start_rise_ff;
  logic [START_PINS-1:0] start_flag_ff;
  logic [START_PINS-1:0] start_sync1_ff;
  logic [START_PINS-1:0] start_sync2_ff;
  logic [START_PINS-1:0] start_prev_ff;
  logic [START_PINS-1:0] start_event;
  logic [4:0]            bod_ctrl_ff;
  logic [RST_SRCS-1:0]   rst_src_ff;
  logic [RST_SRCS-1:0]   rst_req;
  logic                  cfg_clear;
  logic                  bod_rst;
  logic                  spi_lock;
  logic                  wake_deep;
  logic                  wr_pwr_ctrl;
  logic                  wr_start_en;
  logic                  wr_start_rise;
  logic                  wr_start_flag;
  logic                  wr_bod_ctrl;
  logic                  wr_rst_src;
  logic [DATA_W-1:0]     rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  // config returns to defined values while the chip reset holds
  assign cfg_clear     = reset || chip_reset_ff;
  assign wr_pwr_ctrl   = reg_write && (reg_addr == OFS_PWR_CTRL);
  assign wr_start_en   = reg_write && (reg_addr == OFS_START_EN);
  assign wr_start_rise = reg_write && (reg_addr == OFS_START_RISE);
  assign wr_start_flag = reg_write && (reg_addr == OFS_START_FLAG);
  assign wr_bod_ctrl   = reg_write && (reg_addr == OFS_BOD_CTRL);
  assign wr_rst_src    = reg_write && (reg_addr == OFS_RST_SRC);

  // power control bits: deep select, keep watchdog oscillator, keep brownout detector
  always_ff @(posedge clock) begin
    if (cfg_clear) begin
      pwr_ctrl_ff <= '0;
    end else if (wr_pwr_ctrl) begin
      pwr_ctrl_ff <= reg_wdata[2:0];
    end
  end

  // start logic enables and edge polarity, written by software before use
  always_ff @(posedge clock) begin
    if (cfg_clear) begin
      start_en_ff   <= '0;
      start_rise_ff <= '0;
    end else begin
      if (wr_start_en) begin
        start_en_ff <= reg_wdata[START_PINS-1:0];
      end
      if (wr_start_rise) begin
        start_rise_ff <= reg_wdata[START_PINS-1:0];
      end
    end
  end

  // brownout interrupt level, reset level and reset enable
  always_ff @(posedge clock) begin
    if (cfg_clear) begin
      bod_ctrl_ff <= '0;
    end else if (wr_bod_ctrl) begin
      bod_ctrl_ff <= reg_wdata[4:0];
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_mux = RDATA_IDLE;
    unique case (reg_addr)
      OFS_PWR_CTRL:   rd_mux[2:0]            = pwr_ctrl_ff;
      OFS_START_EN:   rd_mux[START_PINS-1:0] = start_en_ff;
      OFS_START_RISE: rd_mux[START_PINS-1:0] = start_rise_ff;
      OFS_START_FLAG: rd_mux[START_PINS-1:0] = start_flag_ff;
      OFS_BOD_CTRL:   rd_mux[4:0]            = bod_ctrl_ff;
      OFS_STATUS: begin
        rd_mux[ST_BOD_BIT]                = brownout_irq_ff;
        rd_mux[ST_PROT_LSB +: 2]          = prot_ff;
        rd_mux[ST_SWD_LOCK_BIT]           = spi_lock;
        rd_mux[ST_PWR_LSB +: 2]           = pwr_ff;
      end
      OFS_RST_SRC:    rd_mux[RST_SRCS-1:0]   = rst_src_ff;
      default:        rd_mux                 = RDATA_IDLE;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata_ff <= RDATA_IDLE;
    end else begin
      reg_rdata_ff <= reg_read ? rd_mux : RDATA_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset pin filter

  // a low level must persist a whole accept window; shorter lows never reach the combiner
  always_comb begin
    if (ext_reset_n) begin
      nxt_rst_low_cnt = '0;
    end else if (rst_low_cnt_ff == RST_CNT_MAX) begin
      nxt_rst_low_cnt = rst_low_cnt_ff;
    end else begin
      nxt_rst_low_cnt = rst_low_cnt_ff + RST_CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rst_low_cnt_ff <= '0;
      pin_rst_ff     <= 1'b0;
    end else begin
      rst_low_cnt_ff <= nxt_rst_low_cnt;
      pin_rst_ff     <= (nxt_rst_low_cnt >= RST_ACCEPT_CNT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset combining and release sequence

  assign bod_rst = bod_ctrl_ff[BOD_RST_EN_BIT]
                   && supply_below_rst[bod_ctrl_ff[BOD_RST_LSB +: BOD_SEL_W]];

  // software request only counts while the release sequence is in run, sleep modes included
  always_comb begin
    rst_req              = '0;
    rst_req[SRC_PIN_BIT] = pin_rst_ff;
    rst_req[SRC_WDT_BIT] = watchdog_timer_reset;
    rst_req[SRC_POR_BIT] = power_on_reset;
    rst_req[SRC_BOD_BIT] = bod_rst;
    rst_req[SRC_SW_BIT]  = sw_reset_req && (seq_ff == SEQ_RUN);
  end

  // hold until sources clear and supply is usable, then flash init, then run
  always_comb begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      SEQ_HOLD: begin
        if (!(|rst_req) && supply_usable) begin
          nxt_seq = SEQ_FLASH;
        end
      end
      SEQ_FLASH: begin
        if (|rst_req) begin
          nxt_seq = SEQ_HOLD;
        end else if (flash_init_done) begin
          nxt_seq = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (|rst_req) begin
          nxt_seq = SEQ_HOLD;
        end
      end
      default: nxt_seq = SEQ_HOLD;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      seq_ff              <= SEQ_HOLD;
      chip_reset_ff       <= 1'b1;
      flash_init_start_ff <= 1'b0;
      boot_address_ff     <= BOOT_ADDRESS;
    end else begin
      seq_ff              <= nxt_seq;
      chip_reset_ff       <= (nxt_seq != SEQ_RUN);
      flash_init_start_ff <= (seq_ff == SEQ_HOLD) && (nxt_seq == SEQ_FLASH);
      boot_address_ff     <= BOOT_ADDRESS;
    end
  end

  // sticky source record, survives chip reset; a new event beats a clear
  always_ff @(posedge clock) begin
    if (reset) begin
      rst_src_ff <= '0;
    end else begin
      rst_src_ff <= (wr_rst_src ? (rst_src_ff & ~reg_wdata[RST_SRCS-1:0]) : rst_src_ff) | rst_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start logic

  // per pin: two stage synchroniser, edge detect, sticky flag, own irq line
  for (genvar i = 0; i < START_PINS; i++) begin : g_start
    always_ff @(posedge clock) begin
      if (reset) begin
        start_sync1_ff[i] <= 1'b0;
        start_sync2_ff[i] <= 1'b0;
        start_prev_ff[i]  <= 1'b0;
      end else begin
        start_sync1_ff[i] <= start_pins[i];
        start_sync2_ff[i] <= start_sync1_ff[i];
        start_prev_ff[i]  <= start_sync2_ff[i];
      end
    end

    assign start_event[i] = start_en_ff[i]
                            && (start_rise_ff[i] ? (start_sync2_ff[i] && !start_prev_ff[i])
                                                 : (!start_sync2_ff[i] && start_prev_ff[i]));

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clock) begin
      if (cfg_clear) begin
        start_flag_ff[i] <= 1'b0;
        start_irq_ff[i]  <= 1'b0;
      end else begin
        start_flag_ff[i] <= (start_flag_ff[i] && !(wr_start_flag && reg_wdata[i])) || start_event[i];
        start_irq_ff[i]  <= start_flag_ff[i] && start_en_ff[i];
      end
    end
  end

  // wake detection runs on this block's always-on clock, not the gated core clock
  assign wake_deep = |(start_flag_ff & start_en_ff);

  //////////////////////////////////////////////////////////////////////////////
  // brownout interrupt

  // level follows the comparator; also readable in status for polling
  always_ff @(posedge clock) begin
    if (cfg_clear) begin
      brownout_irq_ff <= 1'b0;
    end else begin
      brownout_irq_ff <= supply_below_int[bod_ctrl_ff[BOD_INT_LSB +: BOD_SEL_W]];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power modes

  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      PWR_RUN: begin
        if (cpu_sleep_req) begin
          nxt_pwr = pwr_ctrl_ff[PWR_DEEP_SEL_BIT] ? PWR_DEEP : PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (periph_irq_any || (|start_irq_ff) || brownout_irq_ff) begin
          nxt_pwr = PWR_RUN;
        end
      end
      PWR_DEEP: begin
        if (wake_deep) begin
          nxt_pwr = PWR_RUN;
        end
      end
      default: nxt_pwr = PWR_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (cfg_clear) begin
      pwr_ff <= PWR_RUN;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // controls are registered so the rc enable and clock gate never glitch;
  // core clock waits for a settled rc oscillator, which software should select before deep sleep
  always_ff @(posedge clock) begin
    if (reset) begin
      power_ff <= '0;
    end else begin
      power_ff.cpu_halt                  <= chip_reset_ff || (pwr_ff != PWR_RUN);
      power_ff.core_clk_en               <= (pwr_ff != PWR_DEEP) && irc_ready;
      power_ff.internal_rc_oscillator_en <= chip_reset_ff ? supply_usable
                                                          : (pwr_ff != PWR_DEEP);
      power_ff.analog_pd                 <= (pwr_ff == PWR_DEEP);
      power_ff.wdosc_pd                  <= (pwr_ff == PWR_DEEP) && !pwr_ctrl_ff[PWR_WDOSC_KEEP_BIT];
      power_ff.brownout_detector_pd      <= (pwr_ff == PWR_DEEP) && !pwr_ctrl_ff[PWR_BOD_KEEP_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // code read protection and debug access

  assign spi_lock = SHARED_SPI_SWD && spi_enabled;

  // level is latched when flash init completes; reset loads fully locked, a chip reset keeps the last level until then
  always_ff @(posedge clock) begin
    if (reset) begin
      prot_ff <= PROT_THREE;
    end else if ((seq_ff == SEQ_FLASH) && flash_init_done) begin
      if (flash_protect_word == PROT_THREE_WORD) begin
        prot_ff <= PROT_THREE;
      end else if (flash_protect_word == PROT_TWO_WORD) begin
        prot_ff <= PROT_TWO;
      end else if (flash_protect_word == PROT_ONE_WORD) begin
        prot_ff <= PROT_ONE;
      end else begin
        prot_ff <= PROT_NONE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      guard_ff <= '0;
    end else begin
      guard_ff.debug_en                      <= (prot_ff == PROT_NONE) && !spi_lock;
      guard_ff.swd_pins_en                   <= (prot_ff != PROT_THREE) && !spi_lock;
      guard_ff.sector0_lock                  <= (prot_ff == PROT_ONE);
      guard_ff.erase_only                    <= (prot_ff == PROT_TWO);
      guard_ff.in_application_programming_en <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> pmr_properties.sv
// checker: port-level properties of the power mode and reset controller
`default_nettype none
module pmr_properties
  import pmr_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic                  reg_read,
  input wire logic [DATA_W-1:0]     reg_rdata_ff,
  input wire logic                  ext_reset_n,
  input wire logic                  watchdog_timer_reset,
  input wire logic                  power_on_reset,
  input wire logic                  spi_enabled,
  input wire logic                  periph_irq_any,
  input wire logic [START_PINS-1:0] start_pins,
  input wire logic                  chip_reset_ff,
  input wire logic                  flash_init_start_ff,
  input wire logic [DATA_W-1:0]     boot_address_ff,
  input wire pmr_power_type         power_ff,
  input wire pmr_guard_type         guard_ff,
  input wire logic [START_PINS-1:0] start_irq_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain; the synchronous reset silences every property
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // flash start is a lone cycle inside the chip reset, one kick per move from hold to flash init
  sequence flash_pulse;
    flash_init_start_ff ##1 !flash_init_start_ff;
  endsequence
  // guard outputs lag their inputs, so judge them only once the chip has run a while
  sequence run_settled;
    !chip_reset_ff [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!reg_read |=> reg_rdata_ff == RDATA_IDLE) else $error("read data not idle");
  a_pin_reset: assert property (!ext_reset_n |-> ##2 chip_reset_ff) else $error("pin low missed");
  a_src_reset: assert property (watchdog_timer_reset || power_on_reset |=> chip_reset_ff) else $error("no reset");
  a_flash_kick: assert property (flash_init_start_ff |-> chip_reset_ff ##0 flash_pulse) else $error("bad kick");
  a_boot_vector: assert property ($fell(chip_reset_ff) |-> boot_address_ff == BOOT_ADDRESS) else $error("boot");
  a_deep_halts: assert property (power_ff.analog_pd |-> power_ff.cpu_halt) else $error("deep without halt");
  a_sleep_wake: assert property (power_ff.cpu_halt && !power_ff.analog_pd && periph_irq_any
    |-> ##[1:3] !power_ff.cpu_halt) else $error("sleep did not end");
  a_spi_lock: assert property (spi_enabled [*3] |-> !guard_ff.debug_en && !guard_ff.swd_pins_en) else $error("swd");
  a_start_sync: assert property ($changed(start_pins) && start_irq_ff == '0 |=> start_irq_ff == '0)
    else $error("start irq not synchronised");
  a_prog_kept: assert property (run_settled |-> guard_ff.in_application_programming_en) else $error("prog off");
endmodule
bind pmr_ctrl pmr_properties pmr_properties_inst (
  .clock(clock), .reset(reset), .reg_read(reg_read), .reg_rdata_ff(reg_rdata_ff), .ext_reset_n(ext_reset_n),
  .watchdog_timer_reset(watchdog_timer_reset), .power_on_reset(power_on_reset), .spi_enabled(spi_enabled),
  .periph_irq_any(periph_irq_any), .start_pins(start_pins), .chip_reset_ff(chip_reset_ff),
  .flash_init_start_ff(flash_init_start_ff), .boot_address_ff(boot_address_ff), .power_ff(power_ff),
  .guard_ff(guard_ff), .start_irq_ff(start_irq_ff)
);
`default_nettype wire

// >>> pmr_pins_model.sv
// partner: external reset pin and start pin drivers
`default_nettype none
module pmr_pins_model (
  input  wire logic                           clock,
  input  wire logic                           pin_req,
  input  wire logic [pmr_pkg::START_PINS-1:0] start_set,
  output var  logic                           ext_reset_n,
  output var  logic [pmr_pkg::START_PINS-1:0] start_pins
);
  import pmr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // pin rests high on its pull-up; a request pulls it low one full period, past the shortest valid pulse
  initial ext_reset_n = 1'h1;
  always @(posedge clock) ext_reset_n <= !pin_req;
  // wake pins move just after an edge, so the block always sees clean levels
  initial start_pins = '0;
  always @(posedge clock) start_pins <= start_set;
endmodule
`default_nettype wire

// >>> tb_top.sv
// testbench: directed scenarios for the power mode and reset controller
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pmr_pkg::*;
  localparam logic [31:0] LVL_WORD [4] = '{32'h0000_0000, 32'h1111_1111, 32'h2222_2222, 32'h3333_3333};
  // debug, swd, sector lock, erase only, programming per level; level three has its sector lock and erase only bits masked out
  localparam logic [4:0]  GUARD_EXP [4] = '{5'h19, 5'h0d, 5'h0b, 5'h01};
  logic clock = 1'h0, reset = 1'h1, reg_write = 1'h0, reg_read = 1'h0, watchdog_timer_reset = 1'h0;
  logic power_on_reset = 1'h0, sw_reset_req = 1'h0, flash_init_done = 1'h0, cpu_sleep_req = 1'h0;
  logic periph_irq_any = 1'h0, spi_enabled = 1'h0, pin_req = 1'h0, ext_reset_n;
  logic chip_reset_ff, flash_init_start_ff, brownout_irq_ff;
  logic [ADDR_W-1:0]     reg_addr = 8'h00;
  logic [DATA_W-1:0]     reg_wdata = '0, flash_protect_word = '0, reg_rdata_ff, boot_address_ff, rd;
  logic [BOD_LEVELS-1:0] supply_below_int = '0, supply_below_rst = '0;
  logic [START_PINS-1:0] start_set = '0, start_pins, start_irq_ff;
  pmr_power_type         power_ff;
  pmr_guard_type         guard_ff;
  int                    errors = 0, n_checks = 0;
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  pmr_ctrl #(.PROT_ONE_WORD(LVL_WORD[1]), .PROT_TWO_WORD(LVL_WORD[2]), .PROT_THREE_WORD(LVL_WORD[3])) pmr_ctrl_inst (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata_ff(reg_rdata_ff), .ext_reset_n(ext_reset_n), .power_on_reset(power_on_reset),
    .watchdog_timer_reset(watchdog_timer_reset), .supply_usable(1'h1), .supply_below_int(supply_below_int),
    .supply_below_rst(supply_below_rst), .sw_reset_req(sw_reset_req), .flash_init_done(flash_init_done),
    .flash_protect_word(flash_protect_word), .irc_ready(1'h1), .cpu_sleep_req(cpu_sleep_req),
    .periph_irq_any(periph_irq_any), .start_pins(start_pins), .spi_enabled(spi_enabled),
    .chip_reset_ff(chip_reset_ff), .flash_init_start_ff(flash_init_start_ff), .boot_address_ff(boot_address_ff),
    .power_ff(power_ff), .guard_ff(guard_ff), .start_irq_ff(start_irq_ff), .brownout_irq_ff(brownout_irq_ff));
  pmr_pins_model pmr_pins_model_inst (
    .clock(clock), .pin_req(pin_req), .start_set(start_set), .ext_reset_n(ext_reset_n), .start_pins(start_pins));
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one register access; read data is taken in the only cycle it stands
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_write <= we;
    reg_read <= !we;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'h0;
    reg_read <= 1'h0;
    #1 rd = reg_rdata_ff;
  endtask
  // wake pins change, then enough cycles for partner, synchroniser, flag and irq
  task automatic pin_edge(input logic [START_PINS-1:0] v);
    @(posedge clock);
    start_set <= v;
    repeat (8) @(posedge clock);
    #1;
  endtask
  // answer the flash start with the protection word of level lv, then judge the guards
  task automatic boot(input int lv);
    int i = 0;
    while (flash_init_start_ff !== 1'h1 && i < 40) begin
      @(posedge clock);
      #1 i++;
    end
    `CHK("flash_start", 1'h1, flash_init_start_ff)
    @(posedge clock);
    flash_init_done <= 1'h1;
    flash_protect_word <= LVL_WORD[lv];
    @(posedge clock);
    flash_init_done <= 1'h0;
    #1 `CHK("chip_reset", 1'h0, chip_reset_ff)
    `CHK("boot_addr", BOOT_ADDRESS, boot_address_ff)
    bus(1'h0, OFS_STATUS, '0);
    `CHK("prot_level", lv[1:0], rd[2:1])
    `CHK("rc_osc_on", 1'h1, power_ff.internal_rc_oscillator_en)
    `CHK("guard", GUARD_EXP[lv], guard_ff & (lv == 3 ? 5'h19 : 5'h1f))
  endtask
  // each reset source in turn, each reboot with protection level k modulo 4, so the last reboot repeats level zero
  task automatic t_source(input int k);
    bus(1'h1, OFS_RST_SRC, 32'h0000_001f);
    bus(1'h1, OFS_BOD_CTRL, 32'h0000_0018);
    @(posedge clock);
    pin_req <= (k == 0);
    watchdog_timer_reset <= (k == 1);
    power_on_reset <= (k == 2);
    supply_below_rst <= (k == 3) ? 4'h4 : 4'h0;
    sw_reset_req <= (k == 4);
    @(posedge clock);
    pin_req <= 1'h0;
    watchdog_timer_reset <= 1'h0;
    power_on_reset <= 1'h0;
    supply_below_rst <= 4'h0;
    sw_reset_req <= 1'h0;
    boot(k % 4);
    bus(1'h0, OFS_RST_SRC, '0);
    `CHK("reset_cause", 32'h0000_0001 << k, rd)
  endtask
  task automatic t_spi();
    @(posedge clock);
    spi_enabled <= 1'h1;
    repeat (4) @(posedge clock);
    bus(1'h0, OFS_STATUS, '0);
    `CHK("spi_lock", 3'h4, {rd[3], guard_ff.debug_en, guard_ff.swd_pins_en})
    @(posedge clock);
    spi_enabled <= 1'h0;
    bus(1'h0, 8'h40, '0);
    `CHK("unmapped", 32'h0000_0000, rd)
  endtask
  task automatic t_brownout();
    bus(1'h1, OFS_BOD_CTRL, 32'h0000_0001);
    @(posedge clock);
    supply_below_int <= 4'h1;
    repeat (3) @(posedge clock);
    #1 `CHK("bod_unselected", 1'h0, brownout_irq_ff)
    @(posedge clock);
    supply_below_int <= 4'h3;
    repeat (3) @(posedge clock);
    bus(1'h0, OFS_STATUS, '0);
    `CHK("bod_set", 2'h3, {brownout_irq_ff, rd[0]})
    @(posedge clock);
    supply_below_int <= 4'h0;
    repeat (3) @(posedge clock);
    #1 `CHK("bod_clear", 1'h0, brownout_irq_ff)
  endtask
  // start logic is configured before any pin is moved
  task automatic t_start();
    bus(1'h1, OFS_START_EN, 32'h0000_003f);
    bus(1'h1, OFS_START_RISE, 32'h0000_003f);
    for (int k = 0; k < START_PINS; k++) begin
      pin_edge(6'h01 << k);
      `CHK("start_irq", 6'h01 << k, start_irq_ff)
      bus(1'h0, OFS_START_FLAG, '0);
      `CHK("start_flag", 32'h0000_0001 << k, rd)
      bus(1'h1, OFS_START_FLAG, 32'h0000_0001 << k);
      pin_edge(6'h00);
      `CHK("start_clear", 6'h00, start_irq_ff)
    end
  endtask
  task automatic t_power();
    bus(1'h1, OFS_PWR_CTRL, 32'h0000_0001);
    @(posedge clock);
    cpu_sleep_req <= 1'h1;
    @(posedge clock);
    cpu_sleep_req <= 1'h0;
    bus(1'h0, OFS_STATUS, '0);
    `CHK("deep_state", 8'he7, {rd[5:4], power_ff})
    pin_edge(6'h01);
    `CHK("deep_wake", 1'h0, power_ff.cpu_halt)
    bus(1'h1, OFS_START_FLAG, 32'h0000_003f);
    pin_edge(6'h00);
    bus(1'h1, OFS_PWR_CTRL, 32'h0000_0000);
    @(posedge clock);
    cpu_sleep_req <= 1'h1;
    @(posedge clock);
    cpu_sleep_req <= 1'h0;
    repeat (2) @(posedge clock);
    #1 `CHK("sleep_state", 2'h2, {power_ff.cpu_halt, power_ff.analog_pd})
    @(posedge clock);
    periph_irq_any <= 1'h1;
    repeat (3) @(posedge clock);
    #1 `CHK("sleep_wake", 1'h0, power_ff.cpu_halt)
    @(posedge clock);
    periph_irq_any <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'h0;
    boot(0);
    t_spi();
    t_brownout();
    t_start();
    t_power();
    for (int k = 0; k < 5; k++) t_source(k);
    stop_test();
  end
  // the scenarios need well under a thousand cycles; this cuts a hang short
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
